/* File: logic/pra_pkg.sv */
// Purpose: Constants and types for the priority agent request controller
// Assumes: 32-bit AXI4-Lite register port, 10 MHz bus clock
// Notes: Offsets are byte addresses of aligned words
package pra_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PRA_OFS_CTRL = 8'h00;
  localparam logic [7:0] PRA_OFS_ADDR = 8'h04;
  localparam logic [7:0] PRA_OFS_CMD = 8'h08;
  localparam logic [7:0] PRA_OFS_ATTR = 8'h0c;
  localparam logic [7:0] PRA_OFS_GO = 8'h10;
  localparam logic [7:0] PRA_OFS_STATUS = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PRA_CTRL_HOLD = 0;
  localparam int PRA_CTRL_LOCK = 1;
  localparam int PRA_CTRL_ADDRESS_ERROR_N_EN = 2;
  localparam int PRA_CTRL_WIDTH = 3;
  localparam int PRA_CMD_ADDR_HI = 0;
  localparam int PRA_CMD_A = 4;
  localparam int PRA_CMD_B = 9;
  localparam int PRA_ATTR_ATTR = 0;
  localparam int PRA_ATTR_DID = 8;
  localparam int PRA_ATTR_BE = 16;
  localparam int PRA_ATTR_EXF = 24;
  localparam int PRA_ST_PENDING = 0;
  localparam int PRA_ST_OWN = 1;
  localparam int PRA_ST_PRIO = 2;
  localparam int PRA_ST_RCOUNT = 3;
  localparam int PRA_ST_SCOUNT = 7;
  localparam int PRA_ST_ADDRESS_ERROR_N = 11;
  localparam logic [31:0] PRA_RESET_WORD = 32'h0000_0000;
  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] PRA_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRA_RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing in bus clocks, queue depth in entries
  // ----------------------------------------
  localparam logic [2:0] PRA_INIT_HOLD = 3'h4;
  localparam logic [2:0] PRA_ADDRESS_ERROR_N_HOLD = 3'h4;
  localparam logic [2:0] PRA_LOCK_REARM = 3'h2;
  localparam logic [2:0] PRA_MIN_IDLE = 3'h2;
  localparam logic [2:0] PRA_LAT_FULL = 3'h4;
  localparam logic [2:0] PRA_LAT_SAME = 3'h2;
  localparam logic [2:0] PRA_LAT_NEXT = 3'h3;
  localparam logic [3:0] PRA_IOQ_DEPTH = 4'h8;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum {PRA_ARB_IDLE, PRA_ARB_WAIT, PRA_ARB_OWN} pra_arb_t;
  typedef enum {PRA_PH_IDLE, PRA_PH_A, PRA_PH_B, PRA_PH_GAP} pra_phase_t;
endpackage : pra_pkg

/* File: logic/pra_priority_agent.sv */
// Purpose: Priority agent that arbitrates for and drives request phases
// Assumes: Bus pins synchronous to clk_sys, bus wire resolved outside
// Notes: Software orders requests through AXI4-Lite registers
`timescale 1ns/1ns
module pra_priority_agent
  import pra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bus observation
  input wire logic busReset_n,
  input wire logic bus_init_n,
  input wire logic address_error_n,
  input wire logic addressStrobeIn_n,
  input wire logic busLockIn_n,
  // Request stall and completion
  input wire logic stallFree,
  input wire logic stallThrottled,
  input wire logic responseDone,
  input wire logic snoopDone,
  // Priority request
  output logic priority_bus_request_n,
  // Strobe and lock drive
  output logic addressStrobeOut_n,
  output logic addressStrobeOe_n,
  output logic busLockOut_n,
  output logic busLockOe_n,
  // Request group drive
  output logic requestOe_n,
  output logic [35:3] address_lines,
  output logic [4:0] request_command_a,
  output logic [4:0] request_command_b,
  output logic [7:0] attribute_field,
  output logic [7:0] deferred_id_field,
  output logic [7:0] byte_enables_n,
  output logic [4:0] extended_function_field,
  output logic [1:0] address_parity_n,
  output logic request_parity_n
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic awHave_q, awHave_d, wHave_q, wHave_d, bvalid_q, bvalid_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [PRA_CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
  logic [31:0] addrReg_q, addrReg_d, cmdReg_q, cmdReg_d, attrReg_q, attrReg_d;
  logic pending_q, pending_d, aerrFlag_q, aerrFlag_d;
  pra_arb_t arb_q, arb_d;
  pra_phase_t phase_q, phase_d;
  logic prioReq_q, prioReq_d, forceReq_q, forceReq_d;
  logic [2:0] holdCnt_q, holdCnt_d, arbCnt_q, arbCnt_d;
  logic lockedIssued_q, lockedIssued_d, lockedSecond_q, lockedSecond_d;
  logic throttleUsed_q, throttleUsed_d, adsSeen_q, adsSeen_d;
  logic [3:0] reqCount_q, reqCount_d, snpCount_q, snpCount_d;
  logic lockDrive_q, lockDrive_d;
  logic [74:0] reqOut_q, reqOut_d;
  logic doWrite, resetCond, aerrEvent, holdOk, fastOk, stallOk, issue;
  logic [31:0] status;
  logic [2:0] target;

  // Byte lane merge
  function automatic logic [31:0] praMerge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : praMerge

  // ----------------------------------------
  // Bus slave handshake
  // ----------------------------------------
  assign awready = !awHave_q && !bvalid_q;
  assign wready = !wHave_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign doWrite = awHave_q && wHave_q && !bvalid_q;

  assign status = {20'h00000, aerrFlag_q, snpCount_q, reqCount_q, prioReq_q,
                   arb_q == PRA_ARB_OWN, pending_q};

  always_comb begin
    awHave_d = awHave_q;
    awAddr_d = awAddr_q;
    wHave_d = wHave_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (awvalid && awready) begin
      awHave_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHave_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awAddr_q[1:0] == 2'h0 && awAddr_q <= PRA_OFS_STATUS) ?
                PRA_RESP_OKAY : PRA_RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = PRA_RESP_OKAY;
      case (araddr)
        PRA_OFS_CTRL: rdata_d = {29'h0, ctrl_q};
        PRA_OFS_ADDR: rdata_d = addrReg_q;
        PRA_OFS_CMD: rdata_d = cmdReg_q;
        PRA_OFS_ATTR: rdata_d = attrReg_q;
        PRA_OFS_GO: rdata_d = {31'h0, pending_q};
        PRA_OFS_STATUS: rdata_d = status;
        default: begin
          rdata_d = 32'h0;
          rresp_d = PRA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHave_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= PRA_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= PRA_RESP_OKAY;
    end else begin
      awHave_q <= awHave_d;
      awAddr_q <= awAddr_d;
      wHave_q <= wHave_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_comb begin
    logic [31:0] merged;
    merged = praMerge(32'h0, wData_q, wStrb_q);
    ctrl_d = ctrl_q;
    addrReg_d = addrReg_q;
    cmdReg_d = cmdReg_q;
    attrReg_d = attrReg_q;
    pending_d = pending_q;
    aerrFlag_d = aerrFlag_q;
    if (doWrite) begin
      case (awAddr_q)
        PRA_OFS_CTRL: ctrl_d = wStrb_q[0] ? wData_q[PRA_CTRL_WIDTH-1:0] : ctrl_q;
        PRA_OFS_ADDR: addrReg_d = praMerge(addrReg_q, wData_q, wStrb_q) & 32'hffff_fff8;
        PRA_OFS_CMD: cmdReg_d = praMerge(cmdReg_q, wData_q, wStrb_q) & 32'h0000_3fff;
        PRA_OFS_ATTR: attrReg_d = praMerge(attrReg_q, wData_q, wStrb_q) & 32'h1fff_ffff;
        PRA_OFS_GO: pending_d = pending_q | merged[0];
        PRA_OFS_STATUS: aerrFlag_d = aerrFlag_q & ~merged[PRA_ST_ADDRESS_ERROR_N];
        default: pending_d = pending_q;
      endcase
    end
    if (issue || aerrEvent) begin
      pending_d = 1'b0;
    end
    if (aerrEvent) begin
      aerrFlag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 3'h0;
      addrReg_q <= PRA_RESET_WORD;
      cmdReg_q <= PRA_RESET_WORD;
      attrReg_q <= PRA_RESET_WORD;
      pending_q <= 1'b0;
      aerrFlag_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addrReg_q <= addrReg_d;
      cmdReg_q <= cmdReg_d;
      attrReg_q <= attrReg_d;
      pending_q <= pending_d;
      aerrFlag_q <= aerrFlag_d;
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  assign resetCond = !busReset_n || !bus_init_n;
  assign aerrEvent = ctrl_q[PRA_CTRL_ADDRESS_ERROR_N_EN] && !address_error_n;
  assign holdOk = holdCnt_q <= 3'h1;
  assign fastOk = !addressStrobeIn_n && busLockIn_n;
  assign stallOk = stallFree || (stallThrottled && !throttleUsed_q);
  // Issue holds off while a strobe is seen on the bus, now or the clock before
  assign issue = arb_q == PRA_ARB_OWN && phase_q == PRA_PH_IDLE && pending_q &&
                 reqCount_q < PRA_IOQ_DEPTH && stallOk && addressStrobeIn_n && !adsSeen_q &&
                 !resetCond && !aerrEvent;

  always_comb begin
    arb_d = arb_q;
    prioReq_d = prioReq_q;
    forceReq_d = forceReq_q;
    holdCnt_d = (holdCnt_q != 3'h0) ? holdCnt_q - 3'h1 : 3'h0;
    arbCnt_d = arbCnt_q;
    target = PRA_LAT_FULL;
    if (arbCnt_q == 3'h0 && fastOk) begin
      target = PRA_LAT_SAME;
    end else if (arbCnt_q == 3'h1 && fastOk) begin
      target = PRA_LAT_NEXT;
    end
    if (resetCond) begin
      prioReq_d = 1'b0;
      forceReq_d = 1'b0;
      arb_d = PRA_ARB_IDLE;
      holdCnt_d = PRA_INIT_HOLD;
    end else if (aerrEvent) begin
      prioReq_d = 1'b0;
      arb_d = PRA_ARB_IDLE;
      forceReq_d = lockedSecond_q;
      holdCnt_d = lockedSecond_q ? PRA_LOCK_REARM : PRA_ADDRESS_ERROR_N_HOLD;
    end else begin
      case (arb_q)
        PRA_ARB_IDLE: begin
          if (holdOk && (pending_q || forceReq_q)) begin
            prioReq_d = 1'b1;
            forceReq_d = 1'b0;
            arbCnt_d = 3'h0;
            arb_d = PRA_ARB_WAIT;
          end
        end
        PRA_ARB_WAIT: begin
          if (!busLockIn_n) begin
            arbCnt_d = 3'h0;
          end else if (arbCnt_q == target - PRA_LAT_SAME) begin
            arb_d = PRA_ARB_OWN;
          end else begin
            arbCnt_d = arbCnt_q + 3'h1;
          end
        end
        PRA_ARB_OWN: begin
          if (!pending_q && !ctrl_q[PRA_CTRL_HOLD] && !lockedIssued_q) begin
            prioReq_d = 1'b0;
            holdCnt_d = PRA_MIN_IDLE;
            arb_d = PRA_ARB_IDLE;
          end
        end
        default: arb_d = PRA_ARB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arb_q <= PRA_ARB_IDLE;
      prioReq_q <= 1'b0;
      forceReq_q <= 1'b0;
      holdCnt_q <= PRA_INIT_HOLD;
      arbCnt_q <= 3'h0;
    end else begin
      arb_q <= arb_d;
      prioReq_q <= prioReq_d;
      forceReq_q <= forceReq_d;
      holdCnt_q <= holdCnt_d;
      arbCnt_q <= arbCnt_d;
    end
  end

  assign priority_bus_request_n = !prioReq_q;

  // ----------------------------------------
  // Request phase and tracking
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    adsSeen_d = !addressStrobeIn_n;
    lockedIssued_d = lockedIssued_q && ctrl_q[PRA_CTRL_LOCK];
    lockedSecond_d = lockedSecond_q && ctrl_q[PRA_CTRL_LOCK];
    throttleUsed_d = throttleUsed_q && stallThrottled && !stallFree;
    lockDrive_d = lockDrive_q && ctrl_q[PRA_CTRL_LOCK] && !resetCond;
    reqOut_d = reqOut_q;
    reqCount_d = reqCount_q;
    snpCount_d = snpCount_q;
    case (phase_q)
      PRA_PH_IDLE: begin
        if (issue) begin
          phase_d = PRA_PH_A;
          reqOut_d = {cmdReg_q[PRA_CMD_ADDR_HI +: 4], addrReg_q[31:3],
                      cmdReg_q[PRA_CMD_A +: 5], cmdReg_q[PRA_CMD_B +: 5],
                      attrReg_q[PRA_ATTR_ATTR +: 8], attrReg_q[PRA_ATTR_DID +: 8],
                      attrReg_q[PRA_ATTR_BE +: 8], attrReg_q[PRA_ATTR_EXF +: 5],
                      ~^{cmdReg_q[PRA_CMD_ADDR_HI +: 4], addrReg_q[31:24]}, ~^addrReg_q[23:3],
                      ~^{cmdReg_q[PRA_CMD_A +: 5], cmdReg_q[PRA_CMD_B +: 5]}};
          lockDrive_d = ctrl_q[PRA_CTRL_LOCK];
          lockedIssued_d = ctrl_q[PRA_CTRL_LOCK];
          lockedSecond_d = ctrl_q[PRA_CTRL_LOCK] && lockedIssued_q;
          throttleUsed_d = !stallFree;
        end
      end
      PRA_PH_A: phase_d = PRA_PH_B;
      PRA_PH_B: phase_d = PRA_PH_GAP;
      PRA_PH_GAP: phase_d = PRA_PH_IDLE;
      default: phase_d = PRA_PH_IDLE;
    endcase
    if (adsSeen_q && reqCount_q < PRA_IOQ_DEPTH) begin
      reqCount_d = reqCount_d + 4'h1;
    end
    if (adsSeen_q) begin
      snpCount_d = snpCount_d + 4'h1;
    end
    if ((responseDone || aerrEvent) && reqCount_d != 4'h0) begin
      reqCount_d = reqCount_d - 4'h1;
    end
    if ((snoopDone || aerrEvent) && snpCount_d != 4'h0) begin
      snpCount_d = snpCount_d - 4'h1;
    end
    if (resetCond) begin
      phase_d = PRA_PH_IDLE;
      reqCount_d = 4'h0;
      snpCount_d = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= PRA_PH_IDLE;
      adsSeen_q <= 1'b0;
      lockedIssued_q <= 1'b0;
      lockedSecond_q <= 1'b0;
      throttleUsed_q <= 1'b0;
      lockDrive_q <= 1'b0;
      reqOut_q <= 75'h7;
      reqCount_q <= 4'h0;
      snpCount_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      adsSeen_q <= adsSeen_d;
      lockedIssued_q <= lockedIssued_d;
      lockedSecond_q <= lockedSecond_d;
      throttleUsed_q <= throttleUsed_d;
      lockDrive_q <= lockDrive_d;
      reqOut_q <= reqOut_d;
      reqCount_q <= reqCount_d;
      snpCount_q <= snpCount_d;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign addressStrobeOut_n = phase_q != PRA_PH_A;
  assign addressStrobeOe_n = phase_q != PRA_PH_A && phase_q != PRA_PH_B;
  assign requestOe_n = phase_q != PRA_PH_A && phase_q != PRA_PH_B;
  assign busLockOut_n = !(lockDrive_q && phase_q != PRA_PH_IDLE) && !(lockDrive_q &&
                        lockedIssued_q);
  assign busLockOe_n = busLockOut_n;
  assign {address_lines, request_command_a, request_command_b, attribute_field,
          deferred_id_field, byte_enables_n, extended_function_field, address_parity_n,
          request_parity_n} = reqOut_q;
endmodule : pra_priority_agent

/* File: verification/pra_bus_model.sv */
// Purpose: Symmetric agent and bus wires facing the priority agent
// Assumes: Strobe and lock wires pulled up, resolved here
// Notes: Stall state and responses steered by the bench
`timescale 1ns/1ns
module pra_bus_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Controller drive
  input wire logic priority_bus_request_n,
  input wire logic addressStrobeOut_n,
  input wire logic addressStrobeOe_n,
  input wire logic busLockOut_n,
  input wire logic busLockOe_n,
  // Bench steering
  input wire logic symGo,
  input wire logic symLock,
  input wire logic [1:0] stallMode,
  input wire logic respond,
  // Resolved bus
  output logic addressStrobeIn_n,
  output logic busLockIn_n,
  output logic stallFree,
  output logic stallThrottled,
  output logic responseDone,
  output logic snoopDone
);
  logic symStrobe_q;
  logic [3:0] snoopPipe_q;
  // Released drivers fall back to the pull-up
  assign addressStrobeIn_n = (addressStrobeOe_n | addressStrobeOut_n) & !symStrobe_q;
  assign busLockIn_n = (busLockOe_n | busLockOut_n) & !symLock;
  assign stallFree = stallMode == 2'h0;
  assign stallThrottled = stallMode == 2'h1;
  assign responseDone = respond;
  assign snoopDone = snoopPipe_q[3];
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      symStrobe_q <= 1'b0;
      snoopPipe_q <= 4'h0;
    end else begin
      symStrobe_q <= symGo && !symStrobe_q && addressStrobeIn_n
        && (priority_bus_request_n || symLock);
      snoopPipe_q <= {snoopPipe_q[2:0], !addressStrobeIn_n};
    end
  end
endmodule : pra_bus_model

/* File: verification/pra_priority_agent_assertions.sv */
// Purpose: Port checks for the priority agent controller
// Assumes: One clock domain, reset_n active low
// Notes: Attached by the bind after the module
`timescale 1ns/1ns
module pra_priority_agent_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus observation
  input wire logic busReset_n,
  input wire logic bus_init_n,
  input wire logic addressStrobeIn_n,
  // Controller drive
  input wire logic priority_bus_request_n,
  input wire logic addressStrobeOut_n,
  input wire logic busLockOut_n,
  input wire logic requestOe_n,
  input wire logic [35:3] address_lines,
  input wire logic [4:0] request_command_a,
  input wire logic [1:0] address_parity_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  property p_init_drop;
    (!busReset_n || !bus_init_n) |=> priority_bus_request_n;
  endproperty
  a_init_drop: assert property (p_init_drop) else $error("request kept in bus reset");
  property p_init_hold;
    $rose(bus_init_n) |-> priority_bus_request_n [*3];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("request early after init");
  property p_idle_two;
    $rose(priority_bus_request_n) |-> priority_bus_request_n [*2];
  endproperty
  a_idle_two: assert property (p_idle_two) else $error("request idle too short");
  property p_latency_min;
    $fell(priority_bus_request_n) |-> addressStrobeOut_n [*2];
  endproperty
  a_latency_min: assert property (p_latency_min) else $error("strobe too soon");
  // ----------------------------------------
  // Request phase
  // ----------------------------------------
  property p_strobe_pulse;
    !addressStrobeOut_n |=> addressStrobeOut_n [*2];
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe shape wrong");
  property p_phase_hold;
    !addressStrobeOut_n |-> !requestOe_n ##1 (!requestOe_n && $stable(address_lines)
      && $stable(request_command_a) && $stable(address_parity_n)) ##1 requestOe_n;
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase not two clocks");
  property p_qualifier;
    !addressStrobeOut_n |-> $past(addressStrobeIn_n) && !priority_bus_request_n;
  endproperty
  a_qualifier: assert property (p_qualifier) else $error("strobe without qualifiers");
  property p_lock_first;
    $fell(busLockOut_n) |-> !addressStrobeOut_n;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("lock outside first clock");
endmodule : pra_priority_agent_assertions

bind pra_priority_agent pra_priority_agent_assertions i_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .busReset_n(busReset_n), .bus_init_n(bus_init_n),
  .addressStrobeIn_n(addressStrobeIn_n), .priority_bus_request_n(priority_bus_request_n),
  .addressStrobeOut_n(addressStrobeOut_n), .busLockOut_n(busLockOut_n),
  .requestOe_n(requestOe_n), .address_lines(address_lines),
  .request_command_a(request_command_a), .address_parity_n(address_parity_n));

/* File: verification/pra_testbench.sv */
// Purpose: Self-checking bench for the priority agent controller
// Assumes: AXI4-Lite master tasks, bus model as far side
// Notes: Expectations built from pra_pkg constants
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin numErrors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench
  import pra_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, requestOe_n, request_parity_n;
  logic [1:0] bresp, rresp, resp, address_parity_n;
  logic busReset_n = 1'b1, bus_init_n = 1'b1, address_error_n = 1'b1;
  logic symGo = 1'b0, symLock = 1'b0, respond = 1'b0;
  logic [1:0] stallMode = 2'h0;
  logic addressStrobeIn_n, busLockIn_n, stallFree, stallThrottled, responseDone, snoopDone;
  logic priority_bus_request_n, addressStrobeOut_n, addressStrobeOe_n, busLockOut_n, busLockOe_n;
  logic [35:3] address_lines;
  logic [4:0] request_command_a, request_command_b, extended_function_field;
  logic [7:0] attribute_field, deferred_id_field, byte_enables_n;
  logic [35:0] adrExp = {4'h9, 32'h8765_4328};
  int numErrors = 0, nTests = 0, n, k;
  pra_priority_agent i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .busReset_n(busReset_n), .bus_init_n(bus_init_n),
    .address_error_n(address_error_n), .addressStrobeIn_n(addressStrobeIn_n),
    .busLockIn_n(busLockIn_n), .stallFree(stallFree), .stallThrottled(stallThrottled),
    .responseDone(responseDone), .snoopDone(snoopDone),
    .priority_bus_request_n(priority_bus_request_n), .addressStrobeOut_n(addressStrobeOut_n),
    .addressStrobeOe_n(addressStrobeOe_n), .busLockOut_n(busLockOut_n),
    .busLockOe_n(busLockOe_n), .requestOe_n(requestOe_n), .address_lines(address_lines),
    .request_command_a(request_command_a), .request_command_b(request_command_b),
    .attribute_field(attribute_field), .deferred_id_field(deferred_id_field),
    .byte_enables_n(byte_enables_n), .extended_function_field(extended_function_field),
    .address_parity_n(address_parity_n), .request_parity_n(request_parity_n));
  pra_bus_model i_bus (.clk_sys(clk_sys), .reset_n(reset_n),
    .priority_bus_request_n(priority_bus_request_n), .addressStrobeOut_n(addressStrobeOut_n),
    .addressStrobeOe_n(addressStrobeOe_n), .busLockOut_n(busLockOut_n),
    .busLockOe_n(busLockOe_n), .symGo(symGo), .symLock(symLock), .stallMode(stallMode),
    .respond(respond), .addressStrobeIn_n(addressStrobeIn_n), .busLockIn_n(busLockIn_n),
    .stallFree(stallFree), .stallThrottled(stallThrottled), .responseDone(responseDone),
    .snoopDone(snoopDone));
  initial forever #50 clk_sys = !clk_sys;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results(input bit hung);
    if (hung) numErrors++;
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (wr ? bvalid : rvalid) break;
    end
    resp = wr ? bresp : rresp;
    rd = rdata;
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 40) results(1);
  endtask : axi
  task automatic waitFor(input bit strobe, input int lim, input bit need);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk_sys);
      if (strobe ? !addressStrobeOut_n : !priority_bus_request_n) break;
    end
    if (need && n > lim) results(1);
  endtask : waitFor
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("status", PRA_RESET_WORD, rd)
    axi(1, PRA_OFS_CTRL, 32'h7);
    axi(0, PRA_OFS_CTRL, 0);
    `CHK("ctrl", 32'h7, rd)
    axi(0, 8'h18, 0);
    `CHK("unmapped", {PRA_RESP_SLVERR, 32'h0}, {resp, rd})
    axi(1, PRA_OFS_CTRL, 32'h0);
    symGo <= 1'b1;
    @(posedge clk_sys);
    symGo <= 1'b0;
    repeat (4) @(posedge clk_sys);
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("symcount", 4'h1, rd[PRA_ST_RCOUNT +: 4])
    $display("registers done");
    axi(1, PRA_OFS_ADDR, adrExp[31:0]);
    axi(1, PRA_OFS_CMD, {18'h0, 5'h15, 5'h0a, adrExp[35:32]});
    axi(1, PRA_OFS_ATTR, 32'h1ac3_5e27);
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(0, 20, 1);
    waitFor(1, 20, 1);
    `CHK("latency", 4, n)
    `CHK("addr", adrExp[35:3], address_lines)
    `CHK("first", {5'h0a, ~^adrExp[35:24], ~^adrExp[23:3], ~^{5'h15, 5'h0a}},
      {request_command_a, address_parity_n, request_parity_n})
    @(posedge clk_sys);
    `CHK("second", {5'h15, 8'h27, 8'h5e, 8'hc3, 5'h1a, ~^adrExp[35:24], ~^adrExp[23:3],
      ~^{5'h15, 5'h0a}}, {request_command_b, attribute_field, deferred_id_field, byte_enables_n,
      extended_function_field, address_parity_n, request_parity_n})
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("count", 4'h2, rd[PRA_ST_RCOUNT +: 4])
    $display("request phase done");
    axi(1, PRA_OFS_CTRL, 32'h2);
    symLock <= 1'b1;
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(1, 12, 0);
    `CHK("lockwait", 13, n)
    symLock <= 1'b0;
    waitFor(1, 20, 1);
    `CHK("lockdrive", 1'b0, busLockOut_n)
    axi(1, PRA_OFS_CTRL, 32'h1);
    $display("lock done");
    stallMode <= 2'h2;
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(1, 12, 0);
    `CHK("stalled", 13, n)
    bus_init_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bus_init_n <= 1'b1;
    waitFor(0, 20, 1);
    `CHK("inithold", 1'b1, n >= 4)
    stallMode <= 2'h1;
    waitFor(1, 20, 1);
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(1, 12, 0);
    `CHK("throttled", 13, n)
    stallMode <= 2'h0;
    waitFor(1, 20, 1);
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("initcount", 4'h2, rd[PRA_ST_RCOUNT +: 4])
    $display("stall and init done");
    axi(1, PRA_OFS_CTRL, 32'h5);
    stallMode <= 2'h2;
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(0, 20, 1);
    address_error_n <= 1'b0;
    @(posedge clk_sys);
    address_error_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("aerrdrop", 1'b1, priority_bus_request_n)
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("aerrflag", 2'h2, {rd[PRA_ST_ADDRESS_ERROR_N], rd[PRA_ST_PENDING]})
    axi(1, PRA_OFS_STATUS, 32'h800);
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("aerrclear", 1'b0, rd[PRA_ST_ADDRESS_ERROR_N])
    stallMode <= 2'h0;
    $display("address error done");
    busReset_n <= 1'b0;
    @(posedge clk_sys);
    busReset_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      axi(1, PRA_OFS_GO, 32'h1);
      waitFor(1, 30, 1);
    end
    axi(0, PRA_OFS_STATUS, 0);
    `CHK("full", PRA_IOQ_DEPTH, rd[PRA_ST_RCOUNT +: 4])
    axi(1, PRA_OFS_GO, 32'h1);
    waitFor(1, 15, 0);
    `CHK("saturated", 16, n)
    respond <= 1'b1;
    @(posedge clk_sys);
    respond <= 1'b0;
    waitFor(1, 20, 1);
    $display("saturation done");
    results(0);
  end
endmodule : testbench
